/* File: core/tdcpi_cfg.svh */
// Constants for the tape data channel and priority interrupt block
`ifndef TDCPI_CFG_SVH
`define TDCPI_CFG_SVH
`define TDCPI_ADDR_W 15
`define TDCPI_SYNC_W 10
`define TDCPI_WC_CELL 15'h0020
`define TDCPI_CA_CELL 15'h0021
`define TDCPI_OFF_CTRL 8'h00
`define TDCPI_OFF_STATUS 8'h04
`define TDCPI_OFF_VECTOR 8'h08
`define TDCPI_CTRL_DIR 0
`define TDCPI_CTRL_IE 1
`define TDCPI_CTRL_SPACE 2
`define TDCPI_CTRL_REINIT 3
`define TDCPI_ST_PEND 0
`define TDCPI_ST_REQ 1
`define TDCPI_ST_GRANT 2
`define TDCPI_ST_SHUT 3
`define TDCPI_ST_OVR 4
`define TDCPI_ST_IPEND 5
`define TDCPI_ST_IREQ 6
`define TDCPI_SI_EN_CH 0
`define TDCPI_SI_GRANT 1
`define TDCPI_SI_OVF 2
`define TDCPI_SI_IEN 3
`define TDCPI_SI_IGR 4
`define TDCPI_SI_TP 5
`define TDCPI_SI_READY 6
`define TDCPI_SI_CHAR 7
`define TDCPI_SI_DONE 8
`define TDCPI_SI_FAULT 9
`endif

/* File: core/tdcpi_pkg.sv */
// Types for the tape data channel and priority interrupt block
`include "tdcpi_cfg.svh"
package tdcpi_pkg;
	typedef enum logic [1:0] {
		TDCPI_IDLE = 2'h0,
		TDCPI_REQ = 2'h1,
		TDCPI_GRANT = 2'h3
	} tdcpi_ch_t;

	typedef struct packed {
		tdcpi_ch_t state;
		logic pend;
		logic ovr;
		logic shut;
		logic ipend;
		logic ireq;
		logic vgate;
		logic ctrl_dir;
		logic ctrl_ie;
		logic ctrl_space;
		logic [`TDCPI_ADDR_W-1:0] vec;
		logic ack;
		logic [31:0] rdat;
		logic grant_q;
		logic igr_q;
		logic tp_q;
		logic ready_q;
		logic char_q;
	} tdcpi_state_t;
endpackage

/* File: core/tdcpi_sync.sv */
// Two flip-flop synchroniser for a group of asynchronous levels
`timescale 1ns/10ps
`default_nettype none
module tdcpi_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule // tdcpi_sync
`default_nettype wire

/* File: core/tdcpi_top.sv */
// Tape control data channel requester and priority interrupt requester
// Function
// [R1] Channel services after current instruction completes
// [R2] Word count at 32, address at 33
// [R3] Software loads count as two's complement
// [R4] Software loads address as first minus one
// [R5] Channel steals three input, four output cycles
// [R6] Service latency up to 30 microseconds tolerated
// [R7] Bus position nearer processor wins priority
// [R8] Pass channel enable chain on quickly
// [R9] Synchronise pending flag into channel request
// [R10] Requesting pulls lower devices' enable low
// [R11] Channel grant goes to all devices
// [R12] Granted requester drives word count address
// [R13] Channel increments word count in memory
// [R14] Channel broadcasts overflow when count hits zero
// [R15] Overflow shuts transfers until software reinitialises
// [R16] Read/write requests gated by device selection
// [R17] Channel fetches and increments current address
// [R18] Incremented address locates the data word
// [R19] Interrupt request pulls interrupt chain low
// [R20] Job done or enabled fault sets pending
// [R21] Timing pulse sets interrupt request, asserts line
// [R22] Interrupt grant places service address on bus
// [R23] Interrupt grant clears interrupt pending
// [R24] Pending still set at strobe flags overrun
// [R25] Record spacing selects single-cycle break
// [R26] Completed granted transfer clears pending flag
`timescale 1ns/10ps
`default_nettype none
`include "tdcpi_cfg.svh"
module tdcpi_top (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	input wire logic word_ready_in,
	input wire logic char_strobe_in,
	input wire logic job_done_flag_in,
	input wire logic fault_summary_flag_in,
	input wire logic channel_enable_input_in,
	input wire logic channel_grant_in,
	input wire logic channel_overflow_in,
	input wire logic interrupt_enable_input_in,
	input wire logic interrupt_grant_in,
	input wire logic bus_timing_pulse_in,
	output logic priority_enable_chain_out,
	output logic channel_request_line_out,
	output logic [`TDCPI_ADDR_W-1:0] io_addr_out,
	output logic io_addr_oe_out,
	output logic input_transfer_request_out,
	output logic output_transfer_request_out,
	output logic single_cycle_break_select_out,
	output logic interrupt_enable_output_out,
	output logic processor_interrupt_request_out,
	output logic [`TDCPI_ADDR_W-1:0] vector_out,
	output logic vector_oe_out,
	output logic overrun_error_out
);
	tdcpi_pkg::tdcpi_state_t r, n;
	logic [`TDCPI_SYNC_W-1:0] raw, s;
	logic s_en_ch, s_grant, s_ovf, s_ien, s_igr, s_tp, s_ready, s_char, s_done, s_fault;
	logic grant_rise, igr_rise, tp_rise, ready_rise, char_rise;
	logic bus_hit, wr_ack;
	logic [31:0] status_word;

	// Every bus pin and tape flag is asynchronous to this clock
	assign raw = {fault_summary_flag_in, job_done_flag_in, char_strobe_in, word_ready_in,
		bus_timing_pulse_in, interrupt_grant_in, interrupt_enable_input_in,
		channel_overflow_in, channel_grant_in, channel_enable_input_in};

	tdcpi_sync #(
		.WIDTH(`TDCPI_SYNC_W)
	) u_sync (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.async_in(raw),
		.sync_out(s)
	);

	assign s_en_ch = s[`TDCPI_SI_EN_CH];
	assign s_grant = s[`TDCPI_SI_GRANT];
	assign s_ovf = s[`TDCPI_SI_OVF];
	assign s_ien = s[`TDCPI_SI_IEN];
	assign s_igr = s[`TDCPI_SI_IGR];
	assign s_tp = s[`TDCPI_SI_TP];
	assign s_ready = s[`TDCPI_SI_READY];
	assign s_char = s[`TDCPI_SI_CHAR];
	assign s_done = s[`TDCPI_SI_DONE];
	assign s_fault = s[`TDCPI_SI_FAULT];

	assign grant_rise = s_grant & ~r.grant_q; // R11
	assign igr_rise = s_igr & ~r.igr_q;
	assign tp_rise = s_tp & ~r.tp_q;
	assign ready_rise = s_ready & ~r.ready_q;
	assign char_rise = s_char & ~r.char_q;

	assign bus_hit = wb_cyc_in & wb_stb_in;
	assign wr_ack = bus_hit & wb_we_in & r.ack;

	always_comb begin
		status_word = '0;
		status_word[`TDCPI_ST_PEND] = r.pend;
		status_word[`TDCPI_ST_REQ] = (r.state == tdcpi_pkg::TDCPI_REQ);
		status_word[`TDCPI_ST_GRANT] = (r.state == tdcpi_pkg::TDCPI_GRANT);
		status_word[`TDCPI_ST_SHUT] = r.shut;
		status_word[`TDCPI_ST_OVR] = r.ovr;
		status_word[`TDCPI_ST_IPEND] = r.ipend;
		status_word[`TDCPI_ST_IREQ] = r.ireq;
	end

	always_comb begin
		n = r;
		n.grant_q = s_grant;
		n.igr_q = s_igr;
		n.tp_q = s_tp;
		n.ready_q = s_ready;
		n.char_q = s_char;
		// Classic single cycle: ack one cycle after the strobe, dropped after one
		n.ack = bus_hit & ~r.ack;
		if (bus_hit && !r.ack) begin
			case (wb_adr_in)
				`TDCPI_OFF_CTRL: begin
					n.rdat = '0;
					n.rdat[`TDCPI_CTRL_DIR] = r.ctrl_dir;
					n.rdat[`TDCPI_CTRL_IE] = r.ctrl_ie;
					n.rdat[`TDCPI_CTRL_SPACE] = r.ctrl_space;
				end
				`TDCPI_OFF_STATUS: n.rdat = status_word;
				`TDCPI_OFF_VECTOR: n.rdat = {{(32-`TDCPI_ADDR_W){1'b0}}, r.vec};
				default: n.rdat = '0;
			endcase
		end
		if (wr_ack && wb_adr_in == `TDCPI_OFF_CTRL && wb_sel_in[0]) begin
			n.ctrl_dir = wb_dat_in[`TDCPI_CTRL_DIR];
			n.ctrl_ie = wb_dat_in[`TDCPI_CTRL_IE];
			n.ctrl_space = wb_dat_in[`TDCPI_CTRL_SPACE];
			if (wb_dat_in[`TDCPI_CTRL_REINIT]) begin
				n.shut = 1'b0; // R15
			end
		end
		if (wr_ack && wb_adr_in == `TDCPI_OFF_VECTOR) begin
			if (wb_sel_in[0]) begin
				n.vec[7:0] = wb_dat_in[7:0];
			end
			if (wb_sel_in[1]) begin
				n.vec[`TDCPI_ADDR_W-1:8] = wb_dat_in[`TDCPI_ADDR_W-1:8];
			end
		end
		if (wr_ack && wb_adr_in == `TDCPI_OFF_STATUS && wb_sel_in[0]
			&& wb_dat_in[`TDCPI_ST_OVR]) begin
			n.ovr = 1'b0;
		end
		// Sets of ovr, shut, pend and ipend come after their clears so a coincident event is never lost
		if (char_rise && r.pend) begin
			n.ovr = 1'b1; // R24
		end
		if (r.state == tdcpi_pkg::TDCPI_GRANT && s_ovf) begin
			n.shut = 1'b1; // R14 R15
		end
		case (r.state)
			tdcpi_pkg::TDCPI_IDLE: begin
				if (r.pend && s_en_ch && !r.shut) begin
					n.state = tdcpi_pkg::TDCPI_REQ; // R9
				end
			end
			tdcpi_pkg::TDCPI_REQ: begin
				if (!s_en_ch) begin
					n.state = tdcpi_pkg::TDCPI_IDLE; // R7 R10
				end else if (grant_rise) begin
					n.state = tdcpi_pkg::TDCPI_GRANT; // R11
				end
			end
			tdcpi_pkg::TDCPI_GRANT: begin
				if (!s_grant) begin
					n.state = tdcpi_pkg::TDCPI_IDLE;
					n.pend = 1'b0; // R26
				end
			end
			default: n.state = tdcpi_pkg::TDCPI_IDLE;
		endcase
		if (ready_rise) begin
			n.pend = 1'b1;
		end
		// Interrupt side
		if (igr_rise) begin
			n.ipend = 1'b0; // R23
			n.vgate = r.ireq;
			n.ireq = 1'b0;
		end else if (!s_ien) begin
			n.ireq = 1'b0; // R19
		end else if (tp_rise && r.ipend) begin
			n.ireq = 1'b1; // R21
		end
		if (!s_igr) begin
			n.vgate = 1'b0;
		end
		if (s_done || (s_fault && r.ctrl_ie)) begin
			n.ipend = 1'b1; // R20
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign wb_ack_out = r.ack;
	assign wb_dat_out = r.rdat;
	// Chain passes two cycles after the enable pin; the synchroniser costs that much
	assign priority_enable_chain_out = s_en_ch & (r.state == tdcpi_pkg::TDCPI_IDLE); // R8 R10
	assign channel_request_line_out = (r.state == tdcpi_pkg::TDCPI_REQ); // R9
	assign io_addr_out = `TDCPI_WC_CELL; // R2 R12
	assign io_addr_oe_out = (r.state == tdcpi_pkg::TDCPI_GRANT); // R12
	assign input_transfer_request_out = io_addr_oe_out & ~r.ctrl_dir & ~r.ctrl_space; // R16
	assign output_transfer_request_out = io_addr_oe_out & r.ctrl_dir & ~r.ctrl_space; // R16
	assign single_cycle_break_select_out = r.ctrl_space; // R25
	assign interrupt_enable_output_out = s_ien & ~r.ireq; // R19
	assign processor_interrupt_request_out = r.ireq; // R21
	assign vector_out = r.vec; // R22
	assign vector_oe_out = r.vgate; // R22
	assign overrun_error_out = r.ovr;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence ch_granted_s;
		r.state == tdcpi_pkg::TDCPI_REQ && s_en_ch && grant_rise;
	endsequence

	sequence ch_released_s;
		r.state == tdcpi_pkg::TDCPI_GRANT && !s_grant && !ready_rise;
	endsequence

	// Synchroniser still clears for two edges after reset, so those edges are skipped
	chain_pass_a: assert property ( // R8
		($past(rst_n_in, 2) && channel_enable_input_in
		&& r.state == tdcpi_pkg::TDCPI_IDLE)[*3]
		|-> priority_enable_chain_out)
		else $error("enable chain not passed");

	chain_block_a: assert property ( // R10
		r.state != tdcpi_pkg::TDCPI_IDLE |-> !priority_enable_chain_out)
		else $error("lower device not blocked");

	req_sync_a: assert property ( // R9
		(r.state == tdcpi_pkg::TDCPI_IDLE && r.pend && s_en_ch && !r.shut)
		|=> channel_request_line_out)
		else $error("channel request not raised");

	grant_addr_a: assert property ( // R12
		ch_granted_s |=> io_addr_oe_out && io_addr_out == `TDCPI_WC_CELL)
		else $error("word count address not driven");

	rw_gate_a: assert property ( // R16
		(input_transfer_request_out || output_transfer_request_out) |-> io_addr_oe_out)
		else $error("transfer request while not selected");

	shut_hold_a: assert property ( // R15
		(r.shut && r.state == tdcpi_pkg::TDCPI_IDLE && !wr_ack)
		|=> r.state == tdcpi_pkg::TDCPI_IDLE)
		else $error("transfer after overflow");

	pend_clear_a: assert property ( // R26
		ch_released_s |=> !r.pend && r.state == tdcpi_pkg::TDCPI_IDLE)
		else $error("pending not cleared after transfer");

	overrun_set_a: assert property ( // R24
		(char_rise && r.pend) |=> overrun_error_out)
		else $error("overrun not flagged");

	ipend_set_a: assert property ( // R20
		(s_done || (s_fault && r.ctrl_ie)) |=> r.ipend)
		else $error("interrupt pending not set");

	ipend_clr_a: assert property ( // R23
		(igr_rise && !s_done && !(s_fault && r.ctrl_ie)) |=> !r.ipend)
		else $error("interrupt pending not cleared by grant");

	ireq_set_a: assert property ( // R21
		(tp_rise && r.ipend && s_ien && !igr_rise) |=> processor_interrupt_request_out)
		else $error("interrupt request not set");

	ichain_a: assert property ( // R19
		processor_interrupt_request_out |-> !interrupt_enable_output_out)
		else $error("interrupt chain not pulled low");

	vector_a: assert property ( // R22
		(igr_rise && r.ireq) |=> vector_oe_out && vector_out == $past(r.vec))
		else $error("service address not presented");

	space_a: assert property ( // R25
		single_cycle_break_select_out |-> !input_transfer_request_out
		&& !output_transfer_request_out)
		else $error("data request during spacing");
endmodule // tdcpi_top
`default_nettype wire

/* File: sim/tdcpi_far_model.sv */
// Far-side model of the processor channel and interrupt grant logic
`timescale 1ns/10ps
`default_nettype none
module tdcpi_far_model (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic req_in,
	input wire logic oe_in,
	input wire logic rd_in,
	input wire logic sb_in,
	input wire logic pir_in,
	input wire logic load_in,
	input wire logic [17:0] wc_in,
	output logic grant_out,
	output logic ovf_out,
	output logic igr_out
);
	logic [17:0] wc, ca;
	logic [5:0] cnt;
	logic [2:0] ip;
	logic slow;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			{wc, ca, cnt, ip, slow, grant_out, ovf_out, igr_out} <= '0;
		end else begin
			ip <= {ip[1:0], pir_in};
			igr_out <= ip[2];
			if (load_in) begin
				wc <= wc_in;
				// Data block starts one above this
				ca <= 18'h00fff;
			end
			if (!grant_out) begin
				ovf_out <= 1'b0;
				cnt <= req_in ? cnt + 6'h01 : 6'h00;
				// Alternate prompt and slow service to stress latency
				if (req_in && cnt == (slow ? 6'h1e : 6'h02)) begin
					grant_out <= 1'b1;
					cnt <= 6'h00;
					slow <= !slow;
				end
			end else if (oe_in) begin
				cnt <= cnt + 6'h01;
				if (cnt == 6'h00) begin
					wc <= wc + 18'h00001;
					ovf_out <= wc == 18'h3ffff;
					ca <= sb_in ? ca : ca + 18'h00001;
				end
				if (cnt == (sb_in ? 6'h00 : rd_in ? 6'h02 : 6'h03)) begin
					grant_out <= 1'b0;
					cnt <= 6'h00;
				end
			end
		end
	end
endmodule // tdcpi_far_model
`default_nettype wire

/* File: sim/tdcpi_tb_top.sv */
// Self-checking bench for the tape channel and interrupt block
`timescale 1ns/10ps
`default_nettype none
`include "tdcpi_cfg.svh"
module tdcpi_tb_top;
	logic clk_in, rst_n_in, wb_cyc_in, wb_stb_in, wb_we_in, word_ready_in, char_strobe_in;
	logic job_done_flag_in, fault_summary_flag_in, channel_enable_input_in, load;
	logic interrupt_enable_input_in, bus_timing_pulse_in;
	logic [7:0] wb_adr_in;
	logic [3:0] wb_sel_in;
	logic [31:0] wb_dat_in, rd;
	logic [17:0] wc_init;
	wire channel_grant_in, channel_overflow_in, interrupt_grant_in, wb_ack_out;
	wire priority_enable_chain_out, channel_request_line_out, io_addr_oe_out;
	wire input_transfer_request_out, output_transfer_request_out;
	wire single_cycle_break_select_out, interrupt_enable_output_out;
	wire processor_interrupt_request_out, vector_oe_out, overrun_error_out;
	wire [31:0] wb_dat_out;
	wire [`TDCPI_ADDR_W-1:0] io_addr_out, vector_out;
	int fail_count, total_checks, n;
	tdcpi_top DUT (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
		.wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
		.wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
		.word_ready_in(word_ready_in), .char_strobe_in(char_strobe_in),
		.job_done_flag_in(job_done_flag_in),
		.fault_summary_flag_in(fault_summary_flag_in),
		.channel_enable_input_in(channel_enable_input_in),
		.channel_grant_in(channel_grant_in), .channel_overflow_in(channel_overflow_in),
		.interrupt_enable_input_in(interrupt_enable_input_in),
		.interrupt_grant_in(interrupt_grant_in), .bus_timing_pulse_in(bus_timing_pulse_in),
		.priority_enable_chain_out(priority_enable_chain_out),
		.channel_request_line_out(channel_request_line_out), .io_addr_out(io_addr_out),
		.io_addr_oe_out(io_addr_oe_out),
		.input_transfer_request_out(input_transfer_request_out),
		.output_transfer_request_out(output_transfer_request_out),
		.single_cycle_break_select_out(single_cycle_break_select_out),
		.interrupt_enable_output_out(interrupt_enable_output_out),
		.processor_interrupt_request_out(processor_interrupt_request_out),
		.vector_out(vector_out), .vector_oe_out(vector_oe_out),
		.overrun_error_out(overrun_error_out));
	tdcpi_far_model far (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.req_in(channel_request_line_out),
		.oe_in(io_addr_oe_out), .rd_in(input_transfer_request_out),
		.sb_in(single_cycle_break_select_out), .pir_in(processor_interrupt_request_out),
		.load_in(load), .wc_in(wc_init), .grant_out(channel_grant_in),
		.ovf_out(channel_overflow_in), .igr_out(interrupt_grant_in));
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in <= we;
		wb_adr_in <= a;
		wb_dat_in <= d;
		wb_sel_in <= 4'hf;
		@(posedge clk_in);
		while (wb_ack_out !== 1'b1) @(posedge clk_in);
		rd = wb_dat_out;
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
	endtask
	task tk(input int k);
		repeat (k) @(posedge clk_in);
		#1;
	endtask
	task wait_oe(input logic v);
		for (n = 0; n < 80 && io_addr_oe_out !== v; n++) @(posedge clk_in);
		#1;
	endtask
	task ready_pulse;
		@(posedge clk_in);
		word_ready_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		word_ready_in <= 1'b0;
	endtask
	task regs;
		tk(3);
		chk(io_addr_out, `TDCPI_WC_CELL);
		chk(priority_enable_chain_out, 1);
		wb(0, `TDCPI_OFF_CTRL, 0);
		chk(rd, 0);
		wb(0, `TDCPI_OFF_STATUS, 0);
		chk(rd, 0);
		wb(1, 8'h0c, 32'hffffffff);
		wb(0, 8'h0c, 0);
		chk(rd, 0);
	endtask
	task xfer(input logic [2:0] c);
		wb(1, `TDCPI_OFF_CTRL, {29'h0, c});
		// Control write lands at the acknowledging edge; look once it has settled
		tk(0);
		chk(single_cycle_break_select_out, c[2]);
		ready_pulse;
		for (n = 0; n < 20 && channel_request_line_out !== 1'b1; n++) @(posedge clk_in);
		#1;
		chk(channel_request_line_out, 1);
		chk(priority_enable_chain_out, 0);
		wait_oe(1);
		chk(io_addr_oe_out, 1);
		chk(io_addr_out, `TDCPI_WC_CELL);
		chk({input_transfer_request_out, output_transfer_request_out},
			{30'h0, !c[2] & !c[0], !c[2] & c[0]});
		wait_oe(0);
		tk(2);
		chk(io_addr_oe_out, 0);
		wb(0, `TDCPI_OFF_STATUS, 0);
		chk(rd[`TDCPI_ST_PEND], 0);
	endtask
	task overflow;
		@(posedge clk_in);
		load <= 1'b1;
		wc_init <= 18'h3ffff;
		@(posedge clk_in);
		load <= 1'b0;
		xfer(3'h0);
		chk(rd[`TDCPI_ST_SHUT], 1);
		ready_pulse;
		tk(20);
		chk(channel_request_line_out, 0);
		wb(1, `TDCPI_OFF_CTRL, 32'h8);
		tk(3);
		chk(channel_request_line_out, 1);
		wait_oe(1);
		wait_oe(0);
	endtask
	task overrun;
		@(posedge clk_in) channel_enable_input_in <= 1'b0;
		ready_pulse;
		@(posedge clk_in) char_strobe_in <= 1'b1;
		tk(6);
		chk(overrun_error_out, 1);
		chk(channel_request_line_out, 0);
		@(posedge clk_in) char_strobe_in <= 1'b0;
		wb(1, `TDCPI_OFF_STATUS, 32'h10);
		tk(1);
		chk(overrun_error_out, 0);
		@(posedge clk_in) channel_enable_input_in <= 1'b1;
		wait_oe(1);
		wait_oe(0);
	endtask
	task intr;
		wb(1, `TDCPI_OFF_VECTOR, 32'h1234);
		chk(interrupt_enable_output_out, 1);
		@(posedge clk_in) fault_summary_flag_in <= 1'b1;
		tk(6);
		wb(0, `TDCPI_OFF_STATUS, 0);
		chk(rd[`TDCPI_ST_IPEND], 0);
		wb(1, `TDCPI_OFF_CTRL, 32'h2);
		tk(4);
		wb(0, `TDCPI_OFF_STATUS, 0);
		chk(rd[`TDCPI_ST_IPEND], 1);
		fault_summary_flag_in <= 1'b0;
		@(posedge clk_in) bus_timing_pulse_in <= 1'b1;
		tk(4);
		chk(processor_interrupt_request_out, 1);
		chk(interrupt_enable_output_out, 0);
		for (n = 0; n < 20 && vector_oe_out !== 1'b1; n++) @(posedge clk_in);
		#1;
		chk(vector_oe_out, 1);
		chk(vector_out, 15'h1234);
		for (n = 0; n < 20 && processor_interrupt_request_out !== 1'b0; n++) @(posedge clk_in);
		wb(0, `TDCPI_OFF_STATUS, 0);
		chk(rd[`TDCPI_ST_IPEND], 0);
		bus_timing_pulse_in <= 1'b0;
		@(posedge clk_in) job_done_flag_in <= 1'b1;
		tk(5);
		wb(0, `TDCPI_OFF_STATUS, 0);
		chk(rd[`TDCPI_ST_IPEND], 1);
		job_done_flag_in <= 1'b0;
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		{wb_cyc_in, wb_stb_in, wb_we_in, word_ready_in, char_strobe_in, load} = '0;
		{job_done_flag_in, fault_summary_flag_in, bus_timing_pulse_in} = '0;
		{wb_adr_in, wb_dat_in, wc_init, fail_count, total_checks} = '0;
		{channel_enable_input_in, interrupt_enable_input_in} = 2'h3;
		wb_sel_in = 4'hf;
		rst_n_in = 1'b0;
		repeat (20) @(posedge clk_in);
		rst_n_in <= 1'b1;
		regs;
		xfer(3'h0);
		xfer(3'h1);
		xfer(3'h4);
		overflow;
		overrun;
		intr;
		conclude;
	end
	// Whole run needs a few hundred cycles; this bound only cuts a hang
	initial begin
		#200000;
		fail_count++;
		conclude;
	end
endmodule // tdcpi_tb_top
`default_nettype wire
